// *** shared/qcb_regs.svh ***
// Register offsets, field positions and timing counts of the quadrature unit.
// Assumes a 20 MHz system clock and a byte-addressed 32-bit register port.
`ifndef QCB_REGS_SVH
`define QCB_REGS_SVH
// ===================================================================
// Clock and times
`define QCB_CLK_HZ 20000000
`define QCB_CLK_NS 50
`define QCB_LIM_US 1000
`define QCB_LIM_CYC (`QCB_LIM_US * (`QCB_CLK_HZ / 1000000))
`define QCB_BPP_NS 200
`define QCB_BPP_CYC (`QCB_BPP_NS / `QCB_CLK_NS)
// ===================================================================
// Per-channel registers, channel base is channel times 0x20
`define QCB_CH_STRIDE 8'h20
`define QCB_R_CNT 5'h00
`define QCB_R_CFG 5'h04
`define QCB_R_STAT 5'h08
`define QCB_R_TCAP 5'h0C
`define QCB_R_ICAP 5'h10
`define QCB_R_BPPOS 5'h14
`define QCB_R_BPINT 5'h18
`define QCB_R_MOFS 5'h1C
// Global registers
`define QCB_R_GCTL 8'h80
`define QCB_R_GSTAT 8'h84
// ===================================================================
// Configuration fields
`define QCB_F_FILT 2:0
`define QCB_F_INVA 3
`define QCB_F_INVB 4
`define QCB_F_INVI 5
`define QCB_F_PATA 6
`define QCB_F_PATB 7
`define QCB_F_TEN 8
`define QCB_F_TMODE 10:9
`define QCB_F_BPMODE 12:11
`define QCB_F_BPACT 14:13
`define QCB_F_REFARM 15
`define QCB_F_BPARM 16
// Status bits
`define QCB_S_TRIG 0
`define QCB_S_IDX 1
`define QCB_S_ERR 2
`define QCB_S_BPO 3
`define QCB_S_BPSET 4
`define QCB_S_BPCLR 5
// Global control bits
`define QCB_G_SDEN 0
`define QCB_G_LBYP 1
`define QCB_G_SDCLR 2
`endif

// *** shared/qcb_pkg.sv ***
// Types shared by the quadrature capture and breakpoint unit.
// Assumes four encoder channels.
package qcb_pkg;
	typedef struct packed {logic [3:0] a; logic [3:0] b; logic [3:0] i;} qcb_enc_t;
	typedef struct packed {logic [3:0] home; logic [3:0] rev; logic [3:0] fwd;} qcb_lim_t;
	typedef struct packed {logic inhibit; logic analog_zero; logic step_stop;} qcb_stop_t;
	typedef enum logic [1:0] {QCB_T_LOW, QCB_T_HIGH, QCB_T_RISE, QCB_T_FALL} qcb_tmode_t;
	typedef enum logic [1:0] {QCB_BP_ABS, QCB_BP_MOD, QCB_BP_REL, QCB_BP_RSV} qcb_bpmode_t;
	typedef enum logic [1:0] {QCB_A_HIGH, QCB_A_LOW, QCB_A_TOG, QCB_A_RSV} qcb_bpact_t;
	typedef struct packed {
		logic [1:0] sa, sb, si, st;
		logic fa, fb, fi;
		logic [2:0] ca, cb, ci;
		logic tprev, qprev;
		logic [16:0] cfg;
		logic ftrig, fidx, ferr, bpo, bparm, refarm;
		logic [2:0] pcnt;
		logic [31:0] cnt, tcap, icap, bppos, bpint, mofs, bptgt, mtgt;
	} qcb_ch_t;
	typedef struct packed {
		qcb_ch_t [3:0] ch;
		logic [1:0] ssd;
		logic sdprev, sden, lbyp, sdlat;
		logic [11:0] lim;
		logic [11:0][14:0] lcnt;
		logic [31:0] rdata;
	} qcb_state_t;
endpackage

// *** src/qcb_top.sv ***
// Four-channel quadrature counter with capture, breakpoints, shutdown and limit filter.
// Assumes a 20 MHz clock; encoder, trigger and shutdown pins are asynchronous.
//
// Behaviour
// - four channels, 32-bit signed up/down counters.
// - leading phase sets count direction.
// - every phase edge gives one count; edges on A and B in the same cycle give none and set the error flag.
// - count without loss up to rated rate.
// - programmable noise filter on phases and index.
// - latch count at qualifying index during search.
// - default index qualifies with A, B low.
// - index pattern and input inversions programmable.
// - enabled trigger latches count into capture.
// - trigger acts on level or edge.
// - trigger event flag readable as latched input.
// - move target move_from_capture.
// - shutdown asserts inhibits, zero analog, stops steps.
// - shutdown only on rising edge.
// - breakpoint output changes when count equals position.
// - breakpoint absolute, modulo or relative.
// - preset output, then set, clear or toggle.
// - software sets or clears breakpoint output directly.
// - limit and home need 1 ms, bypassable.
// - breakpoint pulse is 200 ns high.
`include "qcb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module qcb_top import qcb_pkg::*; #(
	parameter logic [14:0] LIM_CYC = 15'(`QCB_LIM_CYC),
	parameter logic [2:0] BPP_CYC = 3'(`QCB_BPP_CYC)
) (
	input wire logic clock, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [7:0] addr, // Register byte address.
	input wire logic [31:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	output logic [31:0] rdata, // Read data, cycle after rd.
	input wire qcb_enc_t enc, // Encoder phases and index.
	input wire logic [3:0] trig_in, // Capture trigger pins.
	input wire logic shutdown_in, // Shutdown pin.
	input wire qcb_lim_t lim_in, // Limit and home switches, active high.
	output logic [11:0] limit_state, // Filtered limit and home levels.
	output logic [3:0] bp_out, // Breakpoint outputs.
	output logic [3:0] bp_pulse, // Breakpoint trigger-bus pulses.
	output qcb_stop_t stop, // Shutdown actions.
	output logic [3:0][31:0] move_target // Targets relative to capture.
);
	qcb_state_t r;
	qcb_state_t n;

	// =================================================================
	// Filter: output follows input once it held for len cycles.
	function automatic logic [3:0] filt(input logic in, input logic f,
			input logic [2:0] c, input logic [2:0] len);
		logic [3:0] res;
		res = {f, 3'h0};
		if (len == 3'h0) begin
			res = {in, 3'h0};
		end else if (in != f) begin
			if (c + 3'h1 >= len) begin
				res = {in, 3'h0};
			end else begin
				res = {f, 3'(c + 3'h1)};
			end
		end
		return res;
	endfunction

	// =================================================================
	// Next state.
	always_comb begin
		logic [16:0] cf;
		logic [3:0] fr;
		logic da, db, up, q, t, act, hit, cw, sw;
		logic [2:0] cs;
		n = r;
		n.rdata = 32'h0;
		cf = 17'h0;
		fr = 4'h0;
		da = 1'b0;
		db = 1'b0;
		up = 1'b0;
		q = 1'b0;
		t = 1'b0;
		act = 1'b0;
		hit = 1'b0;
		cw = 1'b0;
		sw = 1'b0;
		cs = addr[7:5];
		n.ssd = {r.ssd[0], shutdown_in};
		for (int c = 0; c < 4; c++) begin
			cf = r.ch[c].cfg;
			cw = wr && (addr[7] == 1'b0) && (cs == 3'(c));
			sw = cw && (addr[4:0] == `QCB_R_STAT);
			// Inversion is applied ahead of the synchroniser.
			n.ch[c].sa = {r.ch[c].sa[0], enc.a[c] ^ cf[`QCB_F_INVA]};
			n.ch[c].sb = {r.ch[c].sb[0], enc.b[c] ^ cf[`QCB_F_INVB]};
			n.ch[c].si = {r.ch[c].si[0], enc.i[c] ^ cf[`QCB_F_INVI]};
			n.ch[c].st = {r.ch[c].st[0], trig_in[c]};
			fr = filt(r.ch[c].sa[1], r.ch[c].fa, r.ch[c].ca, cf[`QCB_F_FILT]);
			{n.ch[c].fa, n.ch[c].ca} = fr;
			fr = filt(r.ch[c].sb[1], r.ch[c].fb, r.ch[c].cb, cf[`QCB_F_FILT]);
			{n.ch[c].fb, n.ch[c].cb} = fr;
			fr = filt(r.ch[c].si[1], r.ch[c].fi, r.ch[c].ci, cf[`QCB_F_FILT]);
			{n.ch[c].fi, n.ch[c].ci} = fr;
			// Software clears flags first, so a same-cycle event wins.
			if (sw) begin
				n.ch[c].ftrig = r.ch[c].ftrig & ~wdata[`QCB_S_TRIG];
				n.ch[c].fidx = r.ch[c].fidx & ~wdata[`QCB_S_IDX];
				n.ch[c].ferr = r.ch[c].ferr & ~wdata[`QCB_S_ERR];
			end
			// Decoder: one step per filtered edge, one edge per clock at most.
			da = n.ch[c].fa ^ r.ch[c].fa;
			db = n.ch[c].fb ^ r.ch[c].fb;
			if (da && db) begin
				n.ch[c].ferr = 1'b1;
			end else if (da || db) begin
				up = da ? (n.ch[c].fa ^ n.ch[c].fb) : ~(n.ch[c].fa ^ n.ch[c].fb);
				n.ch[c].cnt = up ? r.ch[c].cnt + 32'h1 : r.ch[c].cnt - 32'h1;
			end
			q = n.ch[c].fi && (n.ch[c].fa == cf[`QCB_F_PATA])
				&& (n.ch[c].fb == cf[`QCB_F_PATB]);
			n.ch[c].qprev = q;
			if (q && !r.ch[c].qprev && r.ch[c].refarm) begin
				n.ch[c].icap = r.ch[c].cnt;
				n.ch[c].fidx = 1'b1;
				n.ch[c].refarm = 1'b0;
			end
			t = r.ch[c].st[1];
			n.ch[c].tprev = t;
			case (qcb_tmode_t'(cf[`QCB_F_TMODE]))
				QCB_T_LOW: act = !t && !r.ch[c].ftrig;
				QCB_T_HIGH: act = t && !r.ch[c].ftrig;
				QCB_T_RISE: act = t && !r.ch[c].tprev;
				default: act = !t && r.ch[c].tprev;
			endcase
			if (cf[`QCB_F_TEN] && act) begin
				n.ch[c].tcap = r.ch[c].cnt;
				n.ch[c].ftrig = 1'b1;
			end
			n.ch[c].mtgt = r.ch[c].tcap + r.ch[c].mofs;
			// Breakpoint compare.
			hit = r.ch[c].bparm && (r.ch[c].cnt == r.ch[c].bptgt);
			if (r.ch[c].pcnt != 3'h0) begin
				n.ch[c].pcnt = r.ch[c].pcnt - 3'h1;
			end
			if (hit) begin
				case (qcb_bpact_t'(cf[`QCB_F_BPACT]))
					QCB_A_HIGH: n.ch[c].bpo = 1'b1;
					QCB_A_LOW: n.ch[c].bpo = 1'b0;
					default: n.ch[c].bpo = ~r.ch[c].bpo;
				endcase
				n.ch[c].pcnt = BPP_CYC;
				if (qcb_bpmode_t'(cf[`QCB_F_BPMODE]) == QCB_BP_MOD) begin
					n.ch[c].bptgt = r.ch[c].bptgt + r.ch[c].bpint;
				end else begin
					n.ch[c].bparm = 1'b0;
				end
			end
			// Register writes.
			if (cw) begin
				if (addr[4:0] == `QCB_R_CNT) begin
					n.ch[c].cnt = wdata;
				end else if (addr[4:0] == `QCB_R_CFG) begin
					n.ch[c].cfg = {1'b0, 1'b0, wdata[14:0]};
					if (wdata[`QCB_F_REFARM]) begin
						n.ch[c].refarm = 1'b1;
					end
					if (wdata[`QCB_F_BPARM]) begin
						n.ch[c].bparm = 1'b1;
						if (qcb_bpmode_t'(wdata[`QCB_F_BPMODE]) == QCB_BP_REL) begin
							n.ch[c].bptgt = r.ch[c].cnt + r.ch[c].bppos;
						end else begin
							n.ch[c].bptgt = r.ch[c].bppos;
						end
					end
				end else if (addr[4:0] == `QCB_R_STAT) begin
					if (wdata[`QCB_S_BPSET]) begin
						n.ch[c].bpo = 1'b1;
					end else if (wdata[`QCB_S_BPCLR]) begin
						n.ch[c].bpo = 1'b0;
					end
				end else if (addr[4:0] == `QCB_R_BPPOS) begin
					n.ch[c].bppos = wdata;
				end else if (addr[4:0] == `QCB_R_BPINT) begin
					n.ch[c].bpint = wdata;
				end else if (addr[4:0] == `QCB_R_MOFS) begin
					n.ch[c].mofs = wdata;
				end
			end
		end
		// Shutdown latch; cleared by software, a new edge wins.
		if (wr && addr == `QCB_R_GCTL) begin
			n.sden = wdata[`QCB_G_SDEN];
			n.lbyp = wdata[`QCB_G_LBYP];
			if (wdata[`QCB_G_SDCLR]) begin
				n.sdlat = 1'b0;
			end
		end
		n.sdprev = r.ssd[1];
		if (r.sden && r.ssd[1] && !r.sdprev) begin
			n.sdlat = 1'b1;
		end
		// Limit and home qualification.
		for (int k = 0; k < 12; k++) begin
			if (!lim_in[k]) begin
				n.lim[k] = 1'b0;
				n.lcnt[k] = 15'h0;
			end else if (r.lbyp || r.lcnt[k] == LIM_CYC - 15'h1) begin
				n.lim[k] = 1'b1;
			end else begin
				n.lcnt[k] = r.lcnt[k] + 15'h1;
			end
		end
		// Register reads.
		if (rd) begin
			if (addr == `QCB_R_GCTL) begin
				n.rdata = {29'h0, 1'b0, r.lbyp, r.sden};
			end else if (addr == `QCB_R_GSTAT) begin
				n.rdata = {19'h0, r.lim, r.sdlat};
			end else if (addr[7] == 1'b0 && cs < 3'h4) begin
				if (addr[4:0] == `QCB_R_CNT) begin
					n.rdata = r.ch[cs[1:0]].cnt;
				end else if (addr[4:0] == `QCB_R_CFG) begin
					n.rdata = {15'h0, r.ch[cs[1:0]].bparm, r.ch[cs[1:0]].refarm,
						r.ch[cs[1:0]].cfg[14:0]};
				end else if (addr[4:0] == `QCB_R_STAT) begin
					n.rdata = {28'h0, r.ch[cs[1:0]].bpo, r.ch[cs[1:0]].ferr,
						r.ch[cs[1:0]].fidx, r.ch[cs[1:0]].ftrig};
				end else if (addr[4:0] == `QCB_R_TCAP) begin
					n.rdata = r.ch[cs[1:0]].tcap;
				end else if (addr[4:0] == `QCB_R_ICAP) begin
					n.rdata = r.ch[cs[1:0]].icap;
				end else if (addr[4:0] == `QCB_R_BPPOS) begin
					n.rdata = r.ch[cs[1:0]].bppos;
				end else if (addr[4:0] == `QCB_R_BPINT) begin
					n.rdata = r.ch[cs[1:0]].bpint;
				end else begin
					n.rdata = r.ch[cs[1:0]].mofs;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// =================================================================
	// Outputs.
	assign rdata = r.rdata;
	assign limit_state = r.lim;
	assign stop = {r.sdlat, r.sdlat, r.sdlat};
	for (genvar g = 0; g < 4; g++) begin : g_out
		assign bp_out[g] = r.ch[g].bpo;
		assign bp_pulse[g] = r.ch[g].pcnt != 3'h0;
		assign move_target[g] = r.ch[g].mtgt;
	end

	// =================================================================
	// Checks on channel 0 and the global logic.
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	logic wr0;
	assign wr0 = wr && addr[7:5] == 3'h0;

	a_cnt_hold: assert property ((r.ch[0].fa != $past(r.ch[0].fa)) && (r.ch[0].fb != $past(r.ch[0].fb))
		&& !$past(wr0) |-> r.ch[0].cnt == $past(r.ch[0].cnt) && r.ch[0].ferr)
		else $error("Double phase change altered count.");
	a_cnt_step: assert property (((r.ch[0].fa != $past(r.ch[0].fa)) ^ (r.ch[0].fb != $past(r.ch[0].fb)))
		&& !$past(wr0) |-> (r.ch[0].cnt - $past(r.ch[0].cnt) == 32'h1)
		|| ($past(r.ch[0].cnt) - r.ch[0].cnt == 32'h1))
		else $error("Single edge did not step count by one.");
	a_err_sticky: assert property (r.ch[0].ferr && !wr0 |=> r.ch[0].ferr)
		else $error("Error flag dropped without clear.");
	a_sd_edge: assert property ($rose(r.sdlat) |-> $past(r.ssd[1]) && !$past(r.sdprev)
		&& $past(r.sden))
		else $error("Shutdown without enabled rising edge.");
	a_sd_hold: assert property (stop.inhibit && !(wr && addr == `QCB_R_GCTL) |=> stop.inhibit
		&& stop.step_stop)
		else $error("Shutdown released without software.");
	a_bp_pulse: assert property ($rose(bp_pulse[0]) |-> bp_pulse[0] [*4])
		else $error("Breakpoint pulse shorter than four cycles.");
	a_trig_cap: assert property (r.ch[0].cfg[`QCB_F_TEN] && r.ch[0].cfg[10:9] == 2'h2
		&& r.ch[0].st[1] && !r.ch[0].tprev |=> r.ch[0].ftrig
		&& r.ch[0].tcap == $past(r.ch[0].cnt))
		else $error("Trigger edge did not capture count.");
	a_idx_cap: assert property ($rose(r.ch[0].qprev) && $past(r.ch[0].refarm) && !$past(wr0)
		|-> r.ch[0].icap == $past(r.ch[0].cnt) && !r.ch[0].refarm
		&& r.ch[0].fidx)
		else $error("Index did not capture count.");
	a_lim_delay: assert property ($rose(limit_state[0]) && !$past(r.lbyp)
		|-> $past(r.lcnt[0]) == LIM_CYC - 15'h1)
		else $error("Limit recognised before filter time.");
	c_bp_hit: cover property ($rose(bp_pulse[0]));
	c_sd_trip: cover property ($rose(stop.inhibit));
	c_idx_cap: cover property ($rose(r.ch[0].fidx));
	c_trig_cap: cover property ($rose(r.ch[0].ftrig));
endmodule
`default_nettype wire

// *** tb/qcb_enc_model.sv ***
// Behavioural quadrature encoder that drives the phase and index pins of all channels.
// Assumes one bench process calls its tasks, paced by the system clock.
`timescale 1ns/1ps
`default_nettype none
module qcb_enc_model import qcb_pkg::*; (
	input wire logic clock, // System clock.
	output qcb_enc_t enc // Phase and index pins.
);
	initial enc = '0;
	// ===================================================================
	// Motion
	// One edge on one phase, then gap idle cycles; A leads B going up.
	task automatic step(input int ch, input bit up, input int gap);
		qcb_enc_t n;
		@(posedge clock);
		n = enc;
		n.a[ch] = up ? ~enc.b[ch] : enc.b[ch];
		n.b[ch] = up ? enc.a[ch] : ~enc.a[ch];
		enc <= n;
		repeat (gap) @(posedge clock);
	endtask
	// Toggles the pins in m ({a,b,i}); with hold above zero they return afterwards.
	task automatic flip(input int ch, input logic [2:0] m, input int hold);
		qcb_enc_t n;
		repeat (hold > 0 ? 2 : 1) begin
			@(posedge clock);
			n = enc;
			n.a[ch] = n.a[ch] ^ m[2];
			n.b[ch] = n.b[ch] ^ m[1];
			n.i[ch] = n.i[ch] ^ m[0];
			enc <= n;
			repeat (hold) @(posedge clock);
		end
		repeat (6) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// *** tb/qcb_top_test.sv ***
// Self-checking bench for the quadrature capture and breakpoint unit.
// Assumes the package, the register header and the encoder model are compiled first.
`include "qcb_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module qcb_top_test import qcb_pkg::*; ;
	logic clock, rstn, wr, rd, shutdown_in, lseen;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] trig_in, bp_out, bp_pulse;
	logic [11:0] limit_state;
	logic [3:0][31:0] move_target;
	logic [31:0] cnt [4];
	qcb_enc_t enc;
	qcb_lim_t lim_in;
	qcb_stop_t stop;
	int fail_count, check_count, cyc, pw;
	qcb_top #(.LIM_CYC(15'h8)) u_dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .enc(enc), .trig_in(trig_in),
		.shutdown_in(shutdown_in), .lim_in(lim_in), .limit_state(limit_state),
		.bp_out(bp_out), .bp_pulse(bp_pulse), .stop(stop), .move_target(move_target));
	qcb_enc_model u_enc (.clock(clock), .enc(enc));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (bp_pulse[0]) begin
			pw++;
		end
		if (limit_state[0]) begin
			lseen = 1'b1;
		end
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ===================================================================
	// Register port access and comparison
	function automatic logic [7:0] ra(input int ch, input logic [4:0] r);
		return 8'(ch * 32) | {3'h0, r};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic done(input string s);
		$display("test %s ended: %0d checks, %0d mismatches", s, check_count, fail_count);
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ===================================================================
	// Test sequence
	initial begin
		rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h0; wdata = 32'h0;
		trig_in = 4'h0; shutdown_in = 1'b0; lim_in = '0; lseen = 1'b0;
		tick(16);
		rstn <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			rchk(ra(c, `QCB_R_CNT), 32'h0);
			rchk(ra(c, `QCB_R_STAT), 32'h0);
		end
		rchk(8'hA0, 32'h0);
		rchk(`QCB_R_GSTAT, 32'h0);
		done("reset");
		for (int c = 0; c < 4; c++) begin
			cnt[c] = 32'(c[0] ? -(c * 4 + 4) : c * 4 + 4);
			repeat (c * 4 + 4) u_enc.step(c, !c[0], c);
		end
		tick(6);
		for (int c = 0; c < 4; c++) begin
			rchk(ra(c, `QCB_R_CNT), cnt[c]);
		end
		done("count");
		u_enc.flip(0, 3'h6, 0);
		rchk(ra(0, `QCB_R_STAT), 32'h4);
		rchk(ra(0, `QCB_R_CNT), cnt[0]);
		u_enc.flip(0, 3'h6, 0);
		wreg(ra(0, `QCB_R_STAT), 32'h4);
		rchk(ra(0, `QCB_R_STAT), 32'h0);
		wreg(ra(2, `QCB_R_CFG), 32'h7);
		u_enc.flip(2, 3'h4, 1);
		rchk(ra(2, `QCB_R_CNT), cnt[2]);
		u_enc.step(2, 1'b1, 12);
		cnt[2] = cnt[2] + 32'h1;
		rchk(ra(2, `QCB_R_CNT), cnt[2]);
		done("error and filter");
		wreg(ra(0, `QCB_R_CFG), 32'h8000);
		wreg(ra(1, `QCB_R_CFG), 32'h8040);
		u_enc.flip(0, 3'h1, 3);
		u_enc.flip(1, 3'h1, 3);
		rchk(ra(0, `QCB_R_ICAP), cnt[0]);
		rchk(ra(0, `QCB_R_STAT), 32'h2);
		rchk(ra(0, `QCB_R_CFG), 32'h0);
		rchk(ra(1, `QCB_R_ICAP), 32'h0);
		rchk(ra(1, `QCB_R_CFG), 32'h8040);
		wreg(ra(1, `QCB_R_CFG), 32'h8020);
		tick(6);
		rchk(ra(1, `QCB_R_ICAP), cnt[1]);
		rchk(ra(1, `QCB_R_STAT), 32'h2, 32'h2);
		wreg(ra(1, `QCB_R_CFG), 32'h8);
		wreg(ra(1, `QCB_R_CFG), 32'h18);
		tick(6);
		rchk(ra(1, `QCB_R_CNT), cnt[1] + 32'h2);
		wreg(ra(1, `QCB_R_CFG), 32'h10);
		wreg(ra(1, `QCB_R_CFG), 32'h0);
		tick(6);
		cnt[1] = cnt[1] + 32'h4;
		rchk(ra(1, `QCB_R_CNT), cnt[1]);
		done("index");
		for (int m = 0; m < 4; m++) begin
			wreg(ra(m, `QCB_R_CFG), (32'(m) << 9) | 32'h100);
		end
		@(posedge clock) trig_in <= 4'hF;
		tick(6);
		for (int m = 0; m < 4; m++) begin
			rchk(ra(m, `QCB_R_STAT), 32'(m != 3), 32'h1);
		end
		@(posedge clock) trig_in <= 4'h0;
		tick(6);
		for (int m = 0; m < 4; m++) begin
			rchk(ra(m, `QCB_R_TCAP), cnt[m]);
			rchk(ra(m, `QCB_R_STAT), 32'h1, 32'h1);
		end
		wreg(ra(1, `QCB_R_MOFS), 32'h100);
		tick(2);
		chk(move_target[1], cnt[1] + 32'h100);
		done("trigger");
		pw = 0;
		wreg(ra(0, `QCB_R_BPPOS), 32'h6);
		wreg(ra(0, `QCB_R_CFG), 32'h10000);
		repeat (2) u_enc.step(0, 1'b1, 10);
		chk(32'(bp_out[0]), 32'h1);
		chk(32'(pw), 32'h4);
		wreg(ra(0, `QCB_R_BPPOS), 32'h7);
		wreg(ra(0, `QCB_R_BPINT), 32'h2);
		wreg(ra(0, `QCB_R_CFG), 32'h14800);
		u_enc.step(0, 1'b1, 10);
		chk(32'(bp_out[0]), 32'h0);
		repeat (2) u_enc.step(0, 1'b1, 10);
		chk(32'(bp_out[0]), 32'h1);
		chk(32'(pw), 32'hC);
		wreg(ra(2, `QCB_R_BPPOS), 32'h1);
		wreg(ra(2, `QCB_R_CFG), 32'h15000);
		u_enc.step(2, 1'b1, 10);
		chk(32'(bp_out[2]), 32'h1);
		u_enc.step(2, 1'b0, 10);
		u_enc.step(2, 1'b1, 10);
		chk(32'(bp_out[2]), 32'h1);
		wreg(ra(3, `QCB_R_STAT), 32'h30);
		tick(1);
		chk(32'(bp_out[3]), 32'h1);
		wreg(ra(3, `QCB_R_STAT), 32'h20);
		tick(1);
		chk(32'(bp_out[3]), 32'h0);
		wreg(ra(3, `QCB_R_STAT), 32'h10);
		rchk(ra(3, `QCB_R_STAT), 32'h8, 32'h8);
		wreg(ra(3, `QCB_R_BPPOS), cnt[3] - 32'h1);
		wreg(ra(3, `QCB_R_CFG), 32'h12000);
		u_enc.step(3, 1'b0, 10);
		chk(32'(bp_out[3]), 32'h0);
		done("breakpoint");
		@(posedge clock) shutdown_in <= 1'b1;
		tick(4);
		wreg(`QCB_R_GCTL, 32'h1);
		tick(6);
		chk(32'(stop), 32'h0);
		@(posedge clock) shutdown_in <= 1'b0;
		tick(4);
		@(posedge clock) shutdown_in <= 1'b1;
		tick(6);
		chk(32'(stop), 32'h7);
		rchk(`QCB_R_GSTAT, 32'h1);
		wreg(`QCB_R_GCTL, 32'h5);
		tick(2);
		chk(32'(stop), 32'h0);
		done("shutdown");
		@(posedge clock) lim_in.fwd[0] <= 1'b1;
		tick(5);
		@(posedge clock) lim_in.fwd[0] <= 1'b0;
		tick(4);
		chk(32'(lseen), 32'h0);
		@(posedge clock) lim_in.fwd[0] <= 1'b1;
		tick(12);
		chk(32'(limit_state), 32'h1);
		wreg(`QCB_R_GCTL, 32'h3);
		@(posedge clock) lim_in.home[3] <= 1'b1;
		tick(2);
		chk(32'(limit_state), 32'h801);
		done("limits");
		print_verdict();
	end
endmodule
`default_nettype wire
